// ===== inc/qpot_cfg.svh
// Constants of the quad wiper two-wire link and its controller.
`ifndef QPOT_CFG_SVH
`define QPOT_CFG_SVH
// Contract
// - Answer only addresses with prefix 01011.
// - Low two address bits come from straps.
// - Address byte last bit: 1 read, 0 write.
// - Watch always; accept bytes after address match.
// - START and STOP framed by master, detected.
// - Data changes only while clock low.
// - Every transfer is an eight-bit byte.
// - Shift in on rising clock, MSB first.
// - Serial clock at most 400 kHz.
// - Frame: address byte, instruction, data, then STOP.
// - Lock shift register during 20.2 ms store.
// - Power-up loads wipers from stored values.
// - Stored settings start at mid-scale.
// - Increment or decrement one selected wiper.
// - Shift a wiper left or right.
// - Reload all four wipers from store.
// - Save present wiper into its store.
// - Load any wiper directly with data.
// - Active-low write protect guards the store.
// - Every wiper and store readable and writable.
// - Step and shift commands ignore data byte.

`define QPOT_ADDR_PREFIX 5'h0B
`define QPOT_ADDR_RST 7'h2C
`define QPOT_MID_SCALE 8'h80
`define QPOT_WIPER_MAX 8'hFF

`define QPOT_CLK_NS 50
`define QPOT_SCL_QTR_NS 625
`define QPOT_SCL_QTR_CYC \
  ((`QPOT_SCL_QTR_NS + `QPOT_CLK_NS - 1) / `QPOT_CLK_NS)
`define QPOT_NV_WR_NS 20200000
`define QPOT_NV_WR_CYC (`QPOT_NV_WR_NS / `QPOT_CLK_NS)

`define QPOT_OP_LOAD 4'h1
`define QPOT_OP_INC 4'h2
`define QPOT_OP_DEC 4'h3
`define QPOT_OP_SHL 4'h4
`define QPOT_OP_SHR 4'h5
`define QPOT_OP_RESTORE 4'h6
`define QPOT_OP_SAVE 4'h7
`define QPOT_OP_NV_LOAD 4'h8
`define QPOT_INS_OP_MSB 7
`define QPOT_INS_OP_LSB 4
`define QPOT_INS_NV_BIT 2

`define QPOT_OFF_CTRL 8'h00
`define QPOT_OFF_STATUS 8'h04
`define QPOT_OFF_SADDR 8'h08
`define QPOT_CTRL_GO 0
`define QPOT_CTRL_RW 1
`define QPOT_CTRL_INS_LSB 8
`define QPOT_CTRL_DAT_LSB 16
`define QPOT_STAT_BUSY 0
`define QPOT_STAT_NACK 1
`define QPOT_STAT_RX_LSB 8
`endif

// ===== inc/qpot_if.sv
// Two-wire bus between the controller and the quad wiper device.
`timescale 1ns/1ns
interface qpot_if;
  logic mst_scl_oe;
  logic mst_sda_oe;
  logic dev_sda_oe;
  logic scl;
  logic sda;

  // Open-drain lines with pull-ups: low while any end drives.
  assign scl = ~mst_scl_oe;
  assign sda = ~(mst_sda_oe | dev_sda_oe);

  modport dev (input scl, input sda, output dev_sda_oe);
  modport mst (input sda, output mst_scl_oe, output mst_sda_oe);
endinterface

// ===== inc/qpot_pkg.sv
// Types shared by both ends of the quad wiper link.
package qpot_pkg;

  typedef enum logic [2:0] {
    DS_IDLE, DS_RX, DS_ACK, DS_TX, DS_RACK
  } qpot_dst_e;

  typedef enum logic [1:0] {
    MS_IDLE, MS_START, MS_BIT, MS_STOP
  } qpot_mst_e;

  typedef struct packed {
    logic scl_m, scl_s, scl_p;
    logic sda_m, sda_s, sda_p;
    logic [1:0] strap_m, strap_s;
    logic wp_m, wp_s;
    qpot_dst_e st;
    logic [3:0] bitn;
    logic [1:0] byten;
    logic rw, nack, sda_oe;
    logic [7:0] sh, instr, data;
    logic ptr_nv;
    logic [1:0] ptr_ch;
    logic [3:0][7:0] wiper;
    logic [3:0][7:0] nv;
    logic busy, init;
    logic [18:0] busy_cnt;
  } qpot_dev_s;

  typedef struct packed {
    logic wr_pend;
    logic [7:0] wr_off;
    logic [31:0] hrdata;
    logic [6:0] saddr;
    logic rw, busy, err;
    logic [7:0] instr, data, rx;
    qpot_mst_e st;
    logic [3:0] q;
    logic [1:0] ph;
    logic [3:0] bitn;
    logic [1:0] byten;
    logic scl_oe, sda_oe, sda_m, sda_s;
  } qpot_mst_s;

endpackage

// ===== verification/qpot_link_checker.sv
// Checker of the two-wire bus between the controller and the device.
`timescale 1ns/1ns
module qpot_link_checker (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Drive enables and wire levels
  input wire logic mst_scl_oe,
  input wire logic mst_sda_oe,
  input wire logic dev_sda_oe,
  input wire logic scl,
  input wire logic sda
);
  logic scl_d_reg;
  logic sda_d_reg;
  logic [7:0] rise_cnt_reg;
  logic [7:0] per_cnt_reg;
  logic scl_rise;
  logic start_ev;
  logic stop_ev;

  assign scl_rise = scl & ~scl_d_reg;
  assign start_ev = scl & scl_d_reg & sda_d_reg & ~sda;
  assign stop_ev = scl & scl_d_reg & ~sda_d_reg & sda;

  // Counts clock rises within a frame and cycles between rises.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      scl_d_reg <= 1'b1;
      sda_d_reg <= 1'b1;
      rise_cnt_reg <= 8'h00;
      per_cnt_reg <= 8'hFF;
    end else begin
      scl_d_reg <= scl;
      sda_d_reg <= sda;
      if (start_ev) rise_cnt_reg <= 8'h00;
      else if (scl_rise) rise_cnt_reg <= rise_cnt_reg + 8'h01;
      if (scl_rise) per_cnt_reg <= 8'h01;
      else if (per_cnt_reg != 8'hFF) per_cnt_reg <= per_cnt_reg + 8'h01;
    end
  end

  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  property p_idle_high;
    $rose(hresetn) |-> scl && sda;
  endproperty
  a_idle_high: assert property (p_idle_high)
    else $error("bus not idle after reset");

  property p_start_clk;
    start_ev |-> ##[10:16] !scl;
  endproperty
  a_start_clk: assert property (p_start_clk)
    else $error("clock did not fall after start");

  property p_stop_idle;
    stop_ev |=> (scl && sda) [*8];
  endproperty
  a_stop_idle: assert property (p_stop_idle)
    else $error("bus not idle after stop");

  property p_bit_stable;
    $rose(scl) |=> $stable(sda) [*8];
  endproperty
  a_bit_stable: assert property (p_bit_stable)
    else $error("data moved while clock high");

  property p_dev_sda_low;
    $changed(dev_sda_oe) |-> !scl;
  endproperty
  a_dev_sda_low: assert property (p_dev_sda_low)
    else $error("device moved data while clock high");

  property p_ack_release;
    $rose(dev_sda_oe) |-> ##[1:500] !dev_sda_oe;
  endproperty
  a_ack_release: assert property (p_ack_release)
    else $error("device held data line too long");

  property p_byte_frame;
    stop_ev |-> (rise_cnt_reg % 8'h09) == 8'h01;
  endproperty
  a_byte_frame: assert property (p_byte_frame)
    else $error("frame not whole bytes");

  property p_scl_rate;
    scl_rise |-> per_cnt_reg >= 8'h32;
  endproperty
  a_scl_rate: assert property (p_scl_rate)
    else $error("clock period too short");

  c_start: cover property (start_ev);
  c_stop: cover property (stop_ev);
  c_dev_ack: cover property ($rose(dev_sda_oe));
endmodule

// ===== verification/quad_pot_i2c_slave_control_tb.sv
// Self-checking bench of the controller and device joined by the link.
`timescale 1ns/1ns
`include "qpot_cfg.svh"
module quad_pot_i2c_slave_control_tb;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic [1:0] strap = 2'h2;
  logic wp_n = 1'b1;
  logic hreadyout;
  logic hresp;
  logic [31:0] hrdata;
  logic [31:0] st;
  logic [3:0][7:0] wiper;
  logic nv_busy;
  int error_cnt = 0;
  int tests_run = 0;
  int cyc = 0;
  // Each row: instruction, data byte, expected wiper of the channel.
  logic [23:0] rows [10] = '{24'h114141, 24'h21FF42, 24'h310041,
    24'h410082, 24'h51FF41, 24'h12FFFF, 24'h2200FF, 24'h4200FF,
    24'h130000, 24'h33FF00};

  qpot_if u_qpot_if ();

  qpot_mst u_qpot_mst (.hclk(hclk), .hresetn(hresetn), .hsel(1'b1),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .bus(u_qpot_if.mst));

  qpot_dev #(.NV_WR_CYCLES(4000)) u_qpot_dev (.hclk(hclk),
    .hresetn(hresetn), .bus(u_qpot_if.dev),
    .address_strap_pin_0(strap[0]), .address_strap_pin_1(strap[1]),
    .write_protect_n(wp_n), .wiper_setting_register(wiper),
    .nv_busy(nv_busy));

  qpot_link_checker u_qpot_link_checker (.hclk(hclk), .hresetn(hresetn),
    .mst_scl_oe(u_qpot_if.mst_scl_oe), .mst_sda_oe(u_qpot_if.mst_sda_oe),
    .dev_sda_oe(u_qpot_if.dev_sda_oe), .scl(u_qpot_if.scl),
    .sda(u_qpot_if.sda));

  task automatic finish_test();
    if (error_cnt == 0 && tests_run > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR t=%0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic ahb(input logic wr, input logic [7:0] off,
                     input logic [31:0] wd, output logic [31:0] rd);
    htrans <= 2'h2;
    haddr <= {24'h0, off};
    hwrite <= wr;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
    chk({30'h0, hreadyout, hresp}, 32'h2);
  endtask

  // Sends one frame and polls the status until the link is free.
  task automatic cmd(input logic rw, input logic [7:0] ins,
                     input logic [7:0] dat);
    ahb(1'b1, `QPOT_OFF_CTRL, {8'h0, dat, ins, 6'h0, rw, 1'b1}, st);
    repeat (2) @(posedge hclk);
    st = 32'h1;
    while (st[0] !== 1'b0) begin
      ahb(1'b0, `QPOT_OFF_STATUS, 32'h0, st);
    end
    repeat (8) @(posedge hclk);
  endtask

  task automatic rb(input logic nv, input logic [1:0] ch);
    cmd(1'b0, {5'h0, nv, ch}, 8'h00);
    cmd(1'b1, 8'h00, 8'h00);
  endtask

  initial begin
    forever #25 hclk = ~hclk;
  end

  always @(posedge hclk) begin
    cyc++;
    if (cyc == 90000) begin
      error_cnt++;
      finish_test();
    end
  end

  initial begin
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (2) @(posedge hclk);
    chk(wiper, 32'h80808080);
    chk({31'h0, nv_busy}, 32'h0);
    ahb(1'b1, `QPOT_OFF_SADDR, 32'h2E, st);
    for (int i = 0; i < 10; i++) begin
      cmd(1'b0, rows[i][23:16], rows[i][15:8]);
      chk(wiper[rows[i][17:16]], rows[i][7:0]);
      rb(1'b0, rows[i][17:16]);
      chk(st[15:8], rows[i][7:0]);
    end
    // Wrong strap bits, then a wrong fixed prefix.
    for (int i = 0; i < 2; i++) begin
      ahb(1'b1, `QPOT_OFF_SADDR, i ? 32'h4E : 32'h2C, st);
      cmd(1'b0, 8'h10, 8'h11);
      chk(st[1], 1'b1);
      chk(wiper[0], 8'h80);
    end
    ahb(1'b1, `QPOT_OFF_SADDR, 32'h2E, st);
    wp_n <= 1'b0;
    cmd(1'b0, 8'h71, 8'h00);
    chk({31'h0, nv_busy}, 32'h0);
    wp_n <= 1'b1;
    cmd(1'b0, 8'h71, 8'h00);
    chk({31'h0, nv_busy}, 32'h1);
    cmd(1'b0, 8'h11, 8'h99);
    chk(wiper[1], 8'h41);
    chk(st[1], 1'b1);
    while (nv_busy !== 1'b0) @(posedge hclk);
    cmd(1'b0, 8'h80, 8'h33);
    while (nv_busy !== 1'b0) @(posedge hclk);
    rb(1'b1, 2'h1);
    chk(st[15:8], 8'h41);
    cmd(1'b0, 8'h11, 8'h22);
    cmd(1'b0, 8'h60, 8'h5A);
    chk(wiper, 32'h80804133);
    // Other strap levels move the answering address with them.
    strap <= 2'h1;
    ahb(1'b1, `QPOT_OFF_SADDR, 32'h2D, st);
    cmd(1'b0, 8'h10, 8'h5A);
    chk(st[1], 1'b0);
    chk(wiper[0], 8'h5A);
    hresetn <= 1'b0;
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (2) @(posedge hclk);
    chk(wiper, 32'h80808080);
    finish_test();
  end
endmodule

// ===== verilog/qpot_dev.sv
// Quad wiper device: two-wire slave, wiper registers and setting store.
//
// The placing of the registers and the AHB-Lite interface to the registers were chosen for this implementation.
`timescale 1ns/1ns
`include "qpot_cfg.svh"
module qpot_dev
  import qpot_pkg::*;
#(
  parameter logic [3:0] OP_LOAD = `QPOT_OP_LOAD,
  parameter logic [3:0] OP_INC = `QPOT_OP_INC,
  parameter logic [3:0] OP_DEC = `QPOT_OP_DEC,
  parameter logic [3:0] OP_SHL = `QPOT_OP_SHL,
  parameter logic [3:0] OP_SHR = `QPOT_OP_SHR,
  parameter logic [3:0] OP_RESTORE = `QPOT_OP_RESTORE,
  parameter logic [3:0] OP_SAVE = `QPOT_OP_SAVE,
  parameter logic [3:0] OP_NV_LOAD = `QPOT_OP_NV_LOAD,
  parameter int NV_WR_CYCLES = `QPOT_NV_WR_CYC
) (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Two-wire bus
  qpot_if.dev bus,
  // Straps and protection
  input wire logic address_strap_pin_0,
  input wire logic address_strap_pin_1,
  input wire logic write_protect_n,
  // Wiper settings and store state
  output logic [3:0][7:0] wiper_setting_register,
  output logic nv_busy
);

  function automatic qpot_dev_s dev_rst();
    qpot_dev_s v;
    v = '0;
    v.scl_m = 1'b1;
    v.scl_s = 1'b1;
    v.scl_p = 1'b1;
    v.sda_m = 1'b1;
    v.sda_s = 1'b1;
    v.sda_p = 1'b1;
    v.st = DS_IDLE;
    v.nv = {4{`QPOT_MID_SCALE}};
    v.init = 1'b1;
    return v;
  endfunction

  localparam qpot_dev_s DEV_RST = dev_rst();

  qpot_dev_s r_reg;
  qpot_dev_s r_next;
  logic rise;
  logic fall;
  logic start;
  logic stop;
  logic [6:0] my_addr;
  logic [7:0] rd;
  logic [1:0] ch;
  logic [7:0] w;
  logic [3:0] op;
  logic nv_ok;

  always_comb begin
    r_next = r_reg;
    // Pins pass two flops; the third stage gives the previous level.
    r_next.scl_m = bus.scl;
    r_next.scl_s = r_reg.scl_m;
    r_next.scl_p = r_reg.scl_s;
    r_next.sda_m = bus.sda;
    r_next.sda_s = r_reg.sda_m;
    r_next.sda_p = r_reg.sda_s;
    r_next.strap_m = {address_strap_pin_1, address_strap_pin_0};
    r_next.strap_s = r_reg.strap_m;
    r_next.wp_m = write_protect_n;
    r_next.wp_s = r_reg.wp_m;

    rise = r_reg.scl_s & ~r_reg.scl_p;
    fall = ~r_reg.scl_s & r_reg.scl_p;
    start = r_reg.scl_s & r_reg.scl_p & r_reg.sda_p & ~r_reg.sda_s;
    stop = r_reg.scl_s & r_reg.scl_p & ~r_reg.sda_p & r_reg.sda_s;
    my_addr = {`QPOT_ADDR_PREFIX, r_reg.strap_s};
    rd = r_reg.ptr_nv ? r_reg.nv[r_reg.ptr_ch] : r_reg.wiper[r_reg.ptr_ch];
    ch = r_reg.instr[1:0];
    w = r_reg.wiper[ch];
    op = r_reg.instr[`QPOT_INS_OP_MSB:`QPOT_INS_OP_LSB];
    nv_ok = r_reg.wp_s & ~r_reg.busy;

    if (r_reg.busy) begin
      if (r_reg.busy_cnt == 19'h0) begin
        r_next.busy = 1'b0;
      end else begin
        r_next.busy_cnt = r_reg.busy_cnt - 19'h1;
      end
    end

    if (r_reg.init) begin
      r_next.wiper = r_reg.nv;
      r_next.init = 1'b0;
    end

    if (start) begin
      // A START, repeated or not, always restarts address reception.
      r_next.st = DS_RX;
      r_next.bitn = 4'h0;
      r_next.byten = 2'h0;
      r_next.sda_oe = 1'b0;
      r_next.data = 8'h00;
    end else if (stop) begin
      r_next.st = DS_IDLE;
      r_next.sda_oe = 1'b0;
      // The command runs once its instruction byte has been taken; the data byte need not follow.
      if (!r_reg.rw && r_reg.byten >= 2'h2 && !r_reg.busy) begin
        case (op)
          OP_LOAD: begin
            r_next.wiper[ch] = r_reg.data;
          end
          OP_INC: begin
            if (w != `QPOT_WIPER_MAX) begin
              r_next.wiper[ch] = w + 8'h01;
            end
          end
          OP_DEC: begin
            if (w != 8'h00) begin
              r_next.wiper[ch] = w - 8'h01;
            end
          end
          OP_SHL: begin
            r_next.wiper[ch] = w[7] ? `QPOT_WIPER_MAX : {w[6:0], 1'b0};
          end
          OP_SHR: begin
            r_next.wiper[ch] = {1'b0, w[7:1]};
          end
          OP_RESTORE: begin
            r_next.wiper = r_reg.nv;
          end
          OP_SAVE: begin
            if (nv_ok) begin
              r_next.nv[ch] = w;
              r_next.busy = 1'b1;
              r_next.busy_cnt = 19'(NV_WR_CYCLES - 1);
            end
          end
          OP_NV_LOAD: begin
            if (nv_ok) begin
              r_next.nv[ch] = r_reg.data;
              r_next.busy = 1'b1;
              r_next.busy_cnt = 19'(NV_WR_CYCLES - 1);
            end
          end
          default: begin
          end
        endcase
      end
    end else begin
      case (r_reg.st)
        DS_RX: begin
          if (rise) begin
            r_next.sh = {r_reg.sh[6:0], r_reg.sda_s};
            r_next.bitn = r_reg.bitn + 4'h1;
          end else if (fall && r_reg.bitn == 4'h8) begin
            r_next.bitn = 4'h0;
            if (r_reg.byten == 2'h0) begin
              if (r_reg.sh[7:1] == my_addr) begin
                r_next.rw = r_reg.sh[0];
                r_next.byten = 2'h1;
                r_next.sda_oe = 1'b1;
                r_next.st = DS_ACK;
              end else begin
                r_next.st = DS_IDLE;
              end
            end else if (r_reg.busy) begin
              // Locked: the byte is neither stored nor acknowledged.
              r_next.st = DS_IDLE;
            end else begin
              if (r_reg.byten == 2'h1) begin
                r_next.instr = r_reg.sh;
                r_next.ptr_nv = r_reg.sh[`QPOT_INS_NV_BIT];
                r_next.ptr_ch = r_reg.sh[1:0];
              end else begin
                r_next.data = r_reg.sh;
              end
              if (r_reg.byten != 2'h3) begin
                r_next.byten = r_reg.byten + 2'h1;
              end
              r_next.sda_oe = 1'b1;
              r_next.st = DS_ACK;
            end
          end
        end
        DS_ACK: begin
          if (fall) begin
            r_next.bitn = 4'h0;
            if (r_reg.rw) begin
              r_next.sh = rd;
              r_next.sda_oe = ~rd[7];
              r_next.st = DS_TX;
            end else begin
              r_next.sda_oe = 1'b0;
              r_next.st = DS_RX;
            end
          end
        end
        DS_TX: begin
          if (rise) begin
            r_next.bitn = r_reg.bitn + 4'h1;
          end else if (fall) begin
            if (r_reg.bitn == 4'h8) begin
              r_next.sda_oe = 1'b0;
              r_next.bitn = 4'h0;
              r_next.st = DS_RACK;
            end else begin
              // New bit goes out just after the falling edge.
              r_next.sh = {r_reg.sh[6:0], 1'b0};
              r_next.sda_oe = ~r_reg.sh[6];
            end
          end
        end
        DS_RACK: begin
          if (rise) begin
            r_next.nack = r_reg.sda_s;
          end else if (fall) begin
            if (r_reg.nack) begin
              r_next.st = DS_IDLE;
            end else begin
              // Further reads walk through the four channels.
              r_next.ptr_ch = r_reg.ptr_ch + 2'h1;
              r_next.sh = r_reg.ptr_nv ? r_reg.nv[r_reg.ptr_ch + 2'h1]
                                      : r_reg.wiper[r_reg.ptr_ch + 2'h1];
              r_next.sda_oe = ~r_next.sh[7];
              r_next.st = DS_TX;
            end
          end
        end
        default: begin
          r_next.st = DS_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      r_reg <= DEV_RST;
    end else begin
      r_reg <= r_next;
    end
  end

  assign bus.dev_sda_oe = r_reg.sda_oe;
  assign wiper_setting_register = r_reg.wiper;
  assign nv_busy = r_reg.busy;

endmodule

// ===== verilog/qpot_mst.sv
// Two-wire bus master driven from AHB-Lite registers.
`timescale 1ns/1ns
`include "qpot_cfg.svh"
module qpot_mst
  import qpot_pkg::*;
(
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Two-wire bus
  qpot_if.mst bus
);

  localparam logic [3:0] QTR = 4'(`QPOT_SCL_QTR_CYC - 1);

  qpot_mst_s r_reg;
  qpot_mst_s r_next;
  logic acc;
  logic writing;
  logic last;
  logic [7:0] tx;
  logic [7:0] txs;

  always_comb begin
    r_next = r_reg;
    r_next.sda_m = bus.sda;
    r_next.sda_s = r_reg.sda_m;

    acc = hsel & htrans[1] & hready & (hsize == 3'h2);
    r_next.wr_pend = acc & hwrite;
    r_next.wr_off = haddr[7:0];
    if (acc && !hwrite) begin
      case (haddr[7:0])
        `QPOT_OFF_CTRL: r_next.hrdata = {8'h00, r_reg.data, r_reg.instr,
                                         6'h00, r_reg.rw, 1'b0};
        `QPOT_OFF_STATUS: r_next.hrdata = {16'h0000, r_reg.rx, 6'h00,
                                           r_reg.err, r_reg.busy};
        `QPOT_OFF_SADDR: r_next.hrdata = {25'h0000000, r_reg.saddr};
        default: r_next.hrdata = 32'h00000000;
      endcase
    end

    tx = (r_reg.byten == 2'h0) ? {r_reg.saddr, r_reg.rw} :
         (r_reg.byten == 2'h1) ? r_reg.instr : r_reg.data;
    txs = tx << r_reg.bitn;
    writing = (r_reg.byten == 2'h0) | ~r_reg.rw;
    last = r_reg.rw ? (r_reg.byten == 2'h1) : (r_reg.byten == 2'h2);

    if (r_reg.wr_pend && !r_reg.busy) begin
      case (r_reg.wr_off)
        `QPOT_OFF_CTRL: begin
          r_next.rw = hwdata[`QPOT_CTRL_RW];
          r_next.instr = hwdata[`QPOT_CTRL_INS_LSB +: 8];
          r_next.data = hwdata[`QPOT_CTRL_DAT_LSB +: 8];
          if (hwdata[`QPOT_CTRL_GO]) begin
            r_next.busy = 1'b1;
            r_next.err = 1'b0;
            r_next.st = MS_START;
            r_next.ph = 2'h0;
            r_next.q = QTR;
            r_next.bitn = 4'h0;
            r_next.byten = 2'h0;
          end
        end
        `QPOT_OFF_SADDR: r_next.saddr = hwdata[6:0];
        default: begin
        end
      endcase
    end

    if (r_reg.busy) begin
      // Each quarter of the bus clock lasts QTR+1 cycles.
      if (r_reg.q != 4'h0) begin
        r_next.q = r_reg.q - 4'h1;
      end else begin
        r_next.q = QTR;
        r_next.ph = r_reg.ph + 2'h1;
        case (r_reg.st)
          MS_START: begin
            if (r_reg.ph == 2'h0) r_next.sda_oe = 1'b1;
            if (r_reg.ph == 2'h1) r_next.scl_oe = 1'b1;
            if (r_reg.ph == 2'h3) r_next.st = MS_BIT;
          end
          MS_BIT: begin
            if (r_reg.ph == 2'h0) begin
              // Data is set only while the clock is low.
              r_next.sda_oe = writing & (r_reg.bitn < 4'h8) & ~txs[7];
            end
            if (r_reg.ph == 2'h1) r_next.scl_oe = 1'b0;
            if (r_reg.ph == 2'h3) begin
              r_next.scl_oe = 1'b1;
              if (r_reg.bitn != 4'h8) begin
                r_next.bitn = r_reg.bitn + 4'h1;
                if (!writing) r_next.rx = {r_reg.rx[6:0], r_reg.sda_s};
              end else begin
                r_next.bitn = 4'h0;
                r_next.byten = r_reg.byten + 2'h1;
                if (writing && r_reg.sda_s) begin
                  r_next.err = 1'b1;
                  r_next.st = MS_STOP;
                end else if (last) begin
                  r_next.st = MS_STOP;
                end
              end
            end
          end
          MS_STOP: begin
            if (r_reg.ph == 2'h0) r_next.sda_oe = 1'b1;
            if (r_reg.ph == 2'h1) r_next.scl_oe = 1'b0;
            if (r_reg.ph == 2'h3) begin
              r_next.sda_oe = 1'b0;
              r_next.busy = 1'b0;
              r_next.st = MS_IDLE;
            end
          end
          default: begin
            r_next.busy = 1'b0;
            r_next.st = MS_IDLE;
          end
        endcase
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      r_reg <= '0;
      r_reg.saddr <= `QPOT_ADDR_RST;
      r_reg.sda_m <= 1'b1;
      r_reg.sda_s <= 1'b1;
    end else begin
      r_reg <= r_next;
    end
  end

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = r_reg.hrdata;
  assign bus.mst_scl_oe = r_reg.scl_oe;
  assign bus.mst_sda_oe = r_reg.sda_oe;

endmodule
